// ### verilog/rac_consts.svh
// register offsets, reset values and field positions of the radio config bank
`ifndef RAC_CONSTS_SVH
`define RAC_CONSTS_SVH

`define RAC_OFF_DAP 12'h620
`define RAC_OFF_DMC 12'h640
`define RAC_OFF_HSP 12'h644
`define RAC_OFF_HSM 12'h648
`define RAC_OFF_MC0 12'h650
`define RAC_OFF_SFD 12'h660
`define RAC_OFF_EDC 12'h664
`define RAC_OFF_EDL 12'h668
`define RAC_OFF_CCA 12'h66c
`define RAC_OFF_DFM 12'h900
`define RAC_OFF_CTE 12'h904

`define RAC_RST_ZERO 32'h0000_0000
`define RAC_RST_DTX 2'h2
`define RAC_RST_SFD 8'ha7
`define RAC_RST_CCA 32'h052d_0000
`define RAC_RST_CTE 32'h0000_2800
`define RAC_MSK_CCA 32'hffff_ff07
`define RAC_MSK_CTE 32'hffff_fcd5

`define RAC_MC0_RU 0
`define RAC_MC0_DTX_LO 8
`define RAC_CTE_PARSE 0
`define RAC_CTE_INS1 2
`define RAC_CTE_CRCERR 4
`define RAC_CTE_TMAX_LO 6

`define RAC_DF_AOD 2'h2
`define RAC_DF_AOA 2'h3
`define RAC_CCA_EDTEST 3'h4

`define RAC_TMAX_SEL20 2'h0
`define RAC_TMAX_SEL31 2'h2
`define RAC_TMAX_SEL63 2'h3
`define RAC_TMAX_20 6'h14
`define RAC_TMAX_31 6'h1f
`define RAC_TMAX_63 6'h3f

`endif

// ### verilog/rac_pkg.sv
// shared types of the radio config bank
package rac_pkg;
   typedef enum logic [0:0] {RAC_ED_IDLE, RAC_ED_RUN} rac_ed_state_e;
   typedef logic [31:0] rac_word_t;
endpackage

// ### verilog/rac_energy_max.sv
// energy-detect scan loop keeping the largest level seen
`timescale 1ns/10ps
module rac_energy_max #(
   parameter int LVL_W = 7,
   parameter int CNT_W = 21
) (
   input wire logic mclk_i, // clock
   input wire logic rst_b_i, // async reset, low
   input wire logic start_i, // begin a scan run
   input wire logic [CNT_W-1:0] scan_count_i, // extra scans
   input wire logic sample_valid_i, // one scan finished
   input wire logic [LVL_W-1:0] sample_i, // level of that scan
   output logic busy_o, // run in progress
   output logic done_o, // run finished, pulse
   output logic [LVL_W-1:0] level_o // largest level of last run
);

   function automatic logic [LVL_W-1:0] lvl_max(input logic [LVL_W-1:0] a,
                                               input logic [LVL_W-1:0] b);
      begin
         lvl_max = (a > b) ? a : b;
      end
   endfunction

   rac_pkg::rac_ed_state_e state_reg, state_next;
   logic [CNT_W-1:0] remain_reg, remain_next;
   logic [LVL_W-1:0] max_reg, max_next;
   logic [LVL_W-1:0] level_reg, level_next;
   logic done_reg, done_next;
   logic busy_reg, busy_next;
   logic [LVL_W-1:0] cur_max;

   always_comb
   begin
      state_next = state_reg;
      remain_next = remain_reg;
      max_next = max_reg;
      level_next = level_reg;
      done_next = 1'b0;
      cur_max = lvl_max(max_reg, sample_i);
      case (state_reg)
         rac_pkg::RAC_ED_IDLE:
         begin
            if (start_i)
            begin
               state_next = rac_pkg::RAC_ED_RUN;
               remain_next = scan_count_i;
               max_next = '0;
            end
         end
         rac_pkg::RAC_ED_RUN:
         begin
            if (sample_valid_i)
            begin
               max_next = cur_max;
               if (remain_reg == '0)
               begin
                  level_next = cur_max;
                  done_next = 1'b1;
                  state_next = rac_pkg::RAC_ED_IDLE;
               end
               else
               begin
                  remain_next = remain_reg - 1'b1;
               end
            end
         end
         default:
         begin
            state_next = rac_pkg::RAC_ED_IDLE;
         end
      endcase
      busy_next = (state_next == rac_pkg::RAC_ED_RUN);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_reg <= rac_pkg::RAC_ED_IDLE;
         busy_reg <= 1'b0;
         remain_reg <= '0;
         max_reg <= '0;
         level_reg <= '0;
         done_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         busy_reg <= busy_next;
         remain_reg <= remain_next;
         max_reg <= max_next;
         level_reg <= level_next;
         done_reg <= done_next;
      end
   end

   assign busy_o = busy_reg;
   assign done_o = done_reg;
   assign level_o = level_reg;

   // scans seen in the current run, for checking only
   logic [CNT_W:0] seen_reg;
   logic [CNT_W:0] want_reg;
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         seen_reg <= '0;
         want_reg <= '0;
      end
      else if (start_i && !busy_o)
      begin
         seen_reg <= '0;
         want_reg <= {1'b0, scan_count_i} + 1'b1;
      end
      else if (busy_o && sample_valid_i)
      begin
         seen_reg <= seen_reg + 1'b1;
      end
   end

   AST_ED_SCAN_COUNT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      done_o |-> seen_reg == want_reg)
      else $error("energy run ended after the wrong number of scans");

   AST_ED_KEEPS_MAX: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (busy_o && sample_valid_i && remain_reg == '0) |=>
      (done_o && level_o >= $past(sample_i) && level_o >= $past(max_reg)))
      else $error("energy level is not the run maximum");

endmodule

// ### verilog/rac_regs.sv
// apb register bank holding the radio auxiliary configuration
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "rac_consts.svh"

// What this block does
// - eight enables for device address compare
// - eight address type flags, one per stored address
// - frame delimiter byte, resets to a7
// - scan count zero gives one scan
// - keep maximum energy over all scans
// - energy level read only, 0 to 127
// - direction mode: 0 off, 2 departure, 3 arrival
// - location bit: 1 in S1, 0 not
// - crc fail bit keeps or stops sampling
module rac_regs #(
   parameter int ADDR_W = 12,
   parameter int LVL_W = 7,
   parameter int CNT_W = 21
) (
   input wire logic mclk_i, // 40 MHz clock
   input wire logic rst_b_i, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic ed_start_i, // radio starts an energy run
   input wire logic ed_sample_valid_i, // one energy scan done
   input wire logic [LVL_W-1:0] ed_sample_i, // energy of that scan
   output logic ed_busy_o, // energy run active
   output logic ed_done_o, // energy run finished pulse
   output logic [7:0] addr_match_en_o, // per-address compare enable
   output logic [7:0] address_type_flag_o, // per-address type flag
   output logic [15:0] device_address_prefix_o, // address prefix
   output logic [31:0] header_search_pattern_o, // search pattern
   output logic [31:0] header_search_mask_o, // search mask
   output logic ramp_up_select_o, // 1 fast ramp-up
   output logic ifs_enforce_o, // hardware keeps interframe spacing
   output logic [1:0] idle_transmit_value_o, // idle tx value
   output logic [7:0] frame_delimiter_o, // start of frame byte
   output logic [2:0] channel_assess_select_o, // assessment mode
   output logic cca_abort_first_busy_o, // energy test mode
   output logic [7:0] channel_energy_threshold_o, // energy threshold
   output logic df_aod_o, // departure mode
   output logic df_aoa_o, // arrival mode
   output logic inline_info_parse_enable_o, // parse extension info
   output logic ext_info_location_o, // 1 info in S1 byte
   output logic crc_fail_sampling_select_o, // sample despite crc fail
   output logic [5:0] ext_time_max_o // largest duration, 8 us units
);

   function automatic logic [5:0] tmax_decode(input logic [1:0] sel);
      begin
         case (sel)
            `RAC_TMAX_SEL31: tmax_decode = `RAC_TMAX_31;
            `RAC_TMAX_SEL63: tmax_decode = `RAC_TMAX_63;
            default: tmax_decode = `RAC_TMAX_20;
         endcase
      end
   endfunction

   logic [15:0] dmc_reg, dmc_next;
   logic [15:0] dap_reg, dap_next;
   logic [31:0] hsp_reg, hsp_next;
   logic [31:0] hsm_reg, hsm_next;
   logic ru_reg, ru_next;
   logic [1:0] dtx_reg, dtx_next;
   logic [7:0] sfd_reg, sfd_next;
   logic [CNT_W-1:0] edc_reg, edc_next;
   rac_pkg::rac_word_t cca_reg, cca_next;
   logic [1:0] dfm_reg, dfm_next;
   rac_pkg::rac_word_t cte_reg, cte_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic ifs_reg, ifs_next;
   logic abort_reg, abort_next;
   logic aod_reg, aod_next;
   logic aoa_reg, aoa_next;
   logic [5:0] tmax_reg, tmax_next;
   logic [LVL_W-1:0] ed_level;
   logic wr_en;
   logic setup;
   logic mapped;
   logic [31:0] rd_word;

   rac_energy_max #(
      .LVL_W(LVL_W),
      .CNT_W(CNT_W)
   ) u_energy (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .start_i(ed_start_i),
      .scan_count_i(edc_reg),
      .sample_valid_i(ed_sample_valid_i),
      .sample_i(ed_sample_i),
      .busy_o(ed_busy_o),
      .done_o(ed_done_o),
      .level_o(ed_level)
   );

   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready_reg && pwrite;

   // read data and decode are sampled in the setup cycle
   always_comb
   begin
      mapped = 1'b1;
      rd_word = '0;
      case (paddr)
         `RAC_OFF_DAP: rd_word = {16'h0000, dap_reg};
         `RAC_OFF_DMC: rd_word = {16'h0000, dmc_reg};
         `RAC_OFF_HSP: rd_word = hsp_reg;
         `RAC_OFF_HSM: rd_word = hsm_reg;
         `RAC_OFF_MC0: rd_word = {22'h0, dtx_reg, 7'h00, ru_reg};
         `RAC_OFF_SFD: rd_word = {24'h0, sfd_reg};
         `RAC_OFF_EDC: rd_word = {{(32 - CNT_W){1'b0}}, edc_reg};
         `RAC_OFF_EDL: rd_word = {{(32 - LVL_W){1'b0}}, ed_level};
         `RAC_OFF_CCA: rd_word = cca_reg;
         `RAC_OFF_DFM: rd_word = {30'h0, dfm_reg};
         `RAC_OFF_CTE: rd_word = cte_reg;
         default: mapped = 1'b0;
      endcase
   end

   always_comb
   begin
      pready_next = setup;
      prdata_next = setup ? rd_word : '0;
      pslverr_next = setup && !mapped;
   end

   always_comb
   begin
      dmc_next = dmc_reg;
      dap_next = dap_reg;
      hsp_next = hsp_reg;
      hsm_next = hsm_reg;
      ru_next = ru_reg;
      dtx_next = dtx_reg;
      sfd_next = sfd_reg;
      edc_next = edc_reg;
      cca_next = cca_reg;
      dfm_next = dfm_reg;
      cte_next = cte_reg;
      if (wr_en)
      begin
         case (paddr)
            `RAC_OFF_DAP: dap_next = pwdata[15:0];
            `RAC_OFF_DMC: dmc_next = pwdata[15:0];
            `RAC_OFF_HSP: hsp_next = pwdata;
            `RAC_OFF_HSM: hsm_next = pwdata;
            `RAC_OFF_MC0:
            begin
               ru_next = pwdata[`RAC_MC0_RU];
               dtx_next = pwdata[`RAC_MC0_DTX_LO +: 2];
            end
            `RAC_OFF_SFD: sfd_next = pwdata[7:0];
            `RAC_OFF_EDC: edc_next = pwdata[CNT_W-1:0];
            `RAC_OFF_CCA: cca_next = pwdata & `RAC_MSK_CCA;
            `RAC_OFF_DFM: dfm_next = pwdata[1:0];
            `RAC_OFF_CTE: cte_next = pwdata & `RAC_MSK_CTE;
            default: dmc_next = dmc_reg; // energy level and holes ignore writes
         endcase
      end
   end

   // decoded views of the configuration, one cycle behind the registers
   always_comb
   begin
      ifs_next = !ru_reg;
      abort_next = (cca_reg[2:0] == `RAC_CCA_EDTEST);
      aod_next = (dfm_reg == `RAC_DF_AOD);
      aoa_next = (dfm_reg == `RAC_DF_AOA);
      tmax_next = tmax_decode(cte_reg[`RAC_CTE_TMAX_LO +: 2]);
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         dmc_reg <= '0;
         dap_reg <= '0;
         hsp_reg <= `RAC_RST_ZERO;
         hsm_reg <= `RAC_RST_ZERO;
         ru_reg <= 1'b0;
         dtx_reg <= `RAC_RST_DTX;
         sfd_reg <= `RAC_RST_SFD;
         edc_reg <= '0;
         cca_reg <= `RAC_RST_CCA;
         dfm_reg <= 2'h0;
         cte_reg <= `RAC_RST_CTE;
         prdata_reg <= `RAC_RST_ZERO;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         ifs_reg <= 1'b1;
         abort_reg <= 1'b0;
         aod_reg <= 1'b0;
         aoa_reg <= 1'b0;
         tmax_reg <= `RAC_TMAX_20;
      end
      else
      begin
         dmc_reg <= dmc_next;
         dap_reg <= dap_next;
         hsp_reg <= hsp_next;
         hsm_reg <= hsm_next;
         ru_reg <= ru_next;
         dtx_reg <= dtx_next;
         sfd_reg <= sfd_next;
         edc_reg <= edc_next;
         cca_reg <= cca_next;
         dfm_reg <= dfm_next;
         cte_reg <= cte_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         ifs_reg <= ifs_next;
         abort_reg <= abort_next;
         aod_reg <= aod_next;
         aoa_reg <= aoa_next;
         tmax_reg <= tmax_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign addr_match_en_o = dmc_reg[7:0];
   assign address_type_flag_o = dmc_reg[15:8];
   assign device_address_prefix_o = dap_reg;
   assign header_search_pattern_o = hsp_reg;
   assign header_search_mask_o = hsm_reg;
   assign ramp_up_select_o = ru_reg;
   assign ifs_enforce_o = ifs_reg;
   assign idle_transmit_value_o = dtx_reg;
   assign frame_delimiter_o = sfd_reg;
   assign channel_assess_select_o = cca_reg[2:0];
   assign cca_abort_first_busy_o = abort_reg;
   assign channel_energy_threshold_o = cca_reg[15:8];
   assign df_aod_o = aod_reg;
   assign df_aoa_o = aoa_reg;
   assign inline_info_parse_enable_o = cte_reg[`RAC_CTE_PARSE];
   assign ext_info_location_o = cte_reg[`RAC_CTE_INS1];
   assign crc_fail_sampling_select_o = cte_reg[`RAC_CTE_CRCERR];
   assign ext_time_max_o = tmax_reg;

   AST_DMC_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (wr_en && paddr == `RAC_OFF_DMC) |=>
      (addr_match_en_o == $past(pwdata[7:0]) && address_type_flag_o == $past(pwdata[15:8])))
      else $error("address match config did not take the write");

   AST_SFD_READBACK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (setup && !pwrite && paddr == `RAC_OFF_SFD) |=>
      (pready && prdata[7:0] == frame_delimiter_o && prdata[31:8] == 24'h0))
      else $error("frame delimiter read back wrong");

   AST_EDL_RO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (wr_en && paddr == `RAC_OFF_EDL) ##1 !ed_done_o |-> $stable(ed_level))
      else $error("energy level changed by a write");

   AST_EDL_RANGE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (setup && paddr == `RAC_OFF_EDL) |=> (prdata[31:7] == 25'h0))
      else $error("energy level read exceeds 127");

   AST_DF_DECODE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (wr_en && paddr == `RAC_OFF_DFM) |-> ##2
      (df_aod_o == ($past(pwdata[1:0], 2) == `RAC_DF_AOD) &&
       df_aoa_o == ($past(pwdata[1:0], 2) == `RAC_DF_AOA)))
      else $error("direction mode decode wrong");

   AST_TMAX: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (cte_reg[`RAC_CTE_TMAX_LO +: 2] == `RAC_TMAX_SEL63) |=> (ext_time_max_o == `RAC_TMAX_63))
      else $error("time range select 3 did not give 63");

   AST_IFS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      ramp_up_select_o |=> !ifs_enforce_o)
      else $error("interframe spacing enforced with fast ramp-up");

   AST_CCA_TEST: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (channel_assess_select_o == `RAC_CCA_EDTEST) |=> cca_abort_first_busy_o)
      else $error("energy test mode not flagged");

   AST_APB_ERR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (setup && !mapped) |=> (pready && pslverr))
      else $error("unmapped address not refused");

   AST_CTE_BITS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (wr_en && paddr == `RAC_OFF_CTE) |=>
      (ext_info_location_o == $past(pwdata[`RAC_CTE_INS1]) &&
       crc_fail_sampling_select_o == $past(pwdata[`RAC_CTE_CRCERR])))
      else $error("extension location or crc handling bit not taken");

   AST_APB_OK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (setup && mapped) |=> (pready && !pslverr))
      else $error("mapped address refused");

endmodule

// ### verification/rac_regs_tb_top.sv
// self-checking bench for the radio config register bank
`timescale 1ns/10ps
`include "rac_consts.svh"
module rac_regs_tb_top;
   logic mclk_i = 0;
   logic rst_b_i = 0;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic ed_start_i = 0, ed_sample_valid_i = 0;
   logic [6:0] ed_sample_i = 0;
   logic ed_busy_o, ed_done_o, ramp_up_select_o, ifs_enforce_o, cca_abort_first_busy_o;
   logic df_aod_o, df_aoa_o, inline_info_parse_enable_o, ext_info_location_o;
   logic crc_fail_sampling_select_o;
   logic [7:0] addr_match_en_o, address_type_flag_o, frame_delimiter_o;
   logic [7:0] channel_energy_threshold_o;
   logic [15:0] device_address_prefix_o;
   logic [31:0] header_search_pattern_o, header_search_mask_o;
   logic [1:0] idle_transmit_value_o;
   logic [2:0] channel_assess_select_o;
   logic [5:0] ext_time_max_o;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [11:0] offs[11] = '{`RAC_OFF_DMC, `RAC_OFF_HSP, `RAC_OFF_HSM, `RAC_OFF_MC0,
      `RAC_OFF_SFD, `RAC_OFF_EDC, `RAC_OFF_EDL, `RAC_OFF_CCA, `RAC_OFF_DFM,
      `RAC_OFF_CTE, `RAC_OFF_DAP};
   logic [31:0] rstv[11] = '{32'h0, 32'h0, 32'h0, 32'h200, 32'ha7, 32'h0, 32'h0,
      32'h052d_0000, 32'h0, 32'h2800, 32'h0};
   logic [5:0] tmax[4] = '{6'h14, 6'h14, 6'h1f, 6'h3f};
   logic [6:0] lv[4] = '{7'h05, 7'h64, 7'h09, 7'h7f};
   logic [31:0] v;
   logic e_seen;
   localparam int ED_SCALE = 4; // energy scaling factor, plain default

   rac_regs dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ed_start_i(ed_start_i), .ed_sample_valid_i(ed_sample_valid_i),
      .ed_sample_i(ed_sample_i), .ed_busy_o(ed_busy_o), .ed_done_o(ed_done_o),
      .addr_match_en_o(addr_match_en_o), .address_type_flag_o(address_type_flag_o),
      .device_address_prefix_o(device_address_prefix_o),
      .header_search_pattern_o(header_search_pattern_o),
      .header_search_mask_o(header_search_mask_o), .ramp_up_select_o(ramp_up_select_o),
      .ifs_enforce_o(ifs_enforce_o), .idle_transmit_value_o(idle_transmit_value_o),
      .frame_delimiter_o(frame_delimiter_o), .channel_assess_select_o(channel_assess_select_o),
      .cca_abort_first_busy_o(cca_abort_first_busy_o),
      .channel_energy_threshold_o(channel_energy_threshold_o), .df_aod_o(df_aod_o),
      .df_aoa_o(df_aoa_o), .inline_info_parse_enable_o(inline_info_parse_enable_o),
      .ext_info_location_o(ext_info_location_o),
      .crc_fail_sampling_select_o(crc_fail_sampling_select_o),
      .ext_time_max_o(ext_time_max_o));

   initial
   begin
      forever #12.5 mclk_i = ~mclk_i;
   end

   task automatic final_report();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // software side scaling of the energy level, saturating at 8 bits
   function automatic logic [7:0] sat_scale(input logic [7:0] lvl);
      int p;
      p = lvl * ED_SCALE;
      return (p > 255) ? 8'hff : p[7:0];
   endfunction

   // one apb transfer; waits for pready, the watchdog ends a hang
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      penable <= 1'b1;
      do
      begin
         @(posedge mclk_i);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      repeat (2) @(posedge mclk_i);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, "read data");
      chk(e, experr, "error response");
   endtask

   // energy run of n+1 scans using the first n+1 levels of lv
   task automatic ed_run(input int n, input logic [6:0] mx);
      wr(`RAC_OFF_EDC, n);
      rdc(`RAC_OFF_EDC, n, 1'b0);
      ed_start_i <= 1'b1;
      @(posedge mclk_i);
      ed_start_i <= 1'b0;
      for (int i = 0; i <= n; i++)
      begin
         ed_sample_valid_i <= 1'b1;
         ed_sample_i <= lv[i];
         @(posedge mclk_i);
         chk(ed_done_o, 1'b0, "early done");
      end
      ed_sample_valid_i <= 1'b0;
      ed_sample_i <= 7'h00;
      @(posedge mclk_i);
      chk(ed_done_o, 1'b1, "done after last scan");
      chk(ed_busy_o, 1'b0, "busy after run");
      rdc(`RAC_OFF_EDL, mx, 1'b0);
   endtask

   initial
   begin
      forever
      begin
         @(posedge mclk_i);
         cyc++;
         if (cyc >= 5000)
         begin
            n_fail++;
            final_report();
         end
      end
   end

   initial
   begin
      repeat (20) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      chk(frame_delimiter_o, 8'ha7, "delimiter reset");
      chk(ext_time_max_o, 6'h14, "time max reset");
      chk(ifs_enforce_o, 1'b1, "spacing reset");
      for (int i = 0; i < 11; i++)
         rdc(offs[i], rstv[i], 1'b0);
      rdc(12'h7fc, 32'h0, 1'b1);
      wr(`RAC_OFF_DAP, 32'h1234_beef);
      chk(device_address_prefix_o, 16'hbeef, "address prefix");
      rdc(`RAC_OFF_DAP, 32'h0000_beef, 1'b0);
      wr(`RAC_OFF_DMC, 32'h0000_a5c3);
      chk(addr_match_en_o, 8'hc3, "match enables");
      chk(address_type_flag_o, 8'ha5, "type flags");
      rdc(`RAC_OFF_DMC, 32'h0000_a5c3, 1'b0);
      wr(`RAC_OFF_HSP, 32'hdead_beef);
      wr(`RAC_OFF_HSM, 32'h0f0f_1234);
      chk(header_search_pattern_o, 32'hdead_beef, "pattern");
      chk(header_search_mask_o, 32'h0f0f_1234, "mask");
      wr(`RAC_OFF_MC0, 32'h0000_0100);
      chk(ramp_up_select_o, 1'b0, "default ramp");
      chk(ifs_enforce_o, 1'b1, "spacing kept");
      chk(idle_transmit_value_o, 2'h1, "idle value one");
      wr(`RAC_OFF_MC0, 32'h0000_0201);
      chk(ramp_up_select_o, 1'b1, "fast ramp");
      chk(ifs_enforce_o, 1'b0, "spacing off");
      chk(idle_transmit_value_o, 2'h2, "centre value");
      wr(`RAC_OFF_SFD, 32'h0000_003c);
      chk(frame_delimiter_o, 8'h3c, "delimiter");
      wr(`RAC_OFF_EDL, 32'hffff_ffff);
      rdc(`RAC_OFF_EDL, 32'h0, 1'b0);
      ed_run(0, lv[0]);
      apb(1'b0, `RAC_OFF_EDL, 32'h0, v, e_seen);
      chk(sat_scale(v[7:0]), 8'h14, "scaled level");
      ed_run(2, lv[1]);
      ed_run(3, lv[3]);
      ed_sample_valid_i <= 1'b1;
      ed_sample_i <= 7'h10;
      @(posedge mclk_i);
      ed_sample_valid_i <= 1'b0;
      rdc(`RAC_OFF_EDL, lv[3], 1'b0);
      apb(1'b0, `RAC_OFF_EDL, 32'h0, v, e_seen);
      chk(sat_scale(v[7:0]), 8'hff, "saturated scaled level");
      for (int m = 0; m < 5; m++)
      begin
         wr(`RAC_OFF_CCA, 32'h052d_4000 | m);
         chk(channel_assess_select_o, m[2:0], "assess mode");
         chk(cca_abort_first_busy_o, m == 4, "abort mode");
         chk(channel_energy_threshold_o, 8'h40, "threshold");
      end
      for (int m = 0; m < 4; m++)
      begin
         wr(`RAC_OFF_DFM, m);
         chk(df_aod_o, m == 2, "departure");
         chk(df_aoa_o, m == 3, "arrival");
         rdc(`RAC_OFF_DFM, m, 1'b0);
      end
      for (int s = 0; s < 4; s++)
      begin
         v = 32'h2800 | (s << 6) | (s[0] ? 32'h15 : 32'h0);
         wr(`RAC_OFF_CTE, v);
         chk(ext_time_max_o, tmax[s], "time max");
         chk(inline_info_parse_enable_o, v[0], "parse enable");
         chk(ext_info_location_o, v[2], "info location");
         chk(crc_fail_sampling_select_o, v[4], "crc handling");
         rdc(`RAC_OFF_CTE, v, 1'b0);
      end
      final_report();
   end
endmodule
